// >>> src/tfma_adapter.sv
// Behaviour
// RQ1 - status strobe drives selected status register
// RQ2 - presence output held high while powered
// RQ3 - command strobe loads address or command byte
// RQ4 - write strobe passes byte to write path
// RQ5 - flag parity error on received command byte
// RQ6 - parity error withholds motion and density
// RQ7 - relay nine read channels to formatter
// RQ8 - read loop clears enable, returns bus bytes
// RQ9 - relay nine active-low amplitude fault lines
// RQ10 - amplitude loop drives lines from registers
// RQ11 - transport status kept current in registers
// RQ12 - write channels fed from strobed bytes
// RQ13 - formatter keeps bus quiet during writes
// RQ14 - accept unit select and maintenance inputs
// RQ15 - drive standard and low threshold outputs
// RQ16 - parity amplitude line is own track
// RQ17 - pulse write strobe after write data; the code raises the strobe in the same clock as the data
// RQ18 - forward, count and report capstan pulses
// RQ19 - test data strobe used in manual test
// RQ20 - write channels map parity and bits 0-7
// RQ21 - bus shared in time, transport lines dedicated
// RQ22 - report late gain control status
// RQ23 - address byte is 100 plus five bits
// RQ24 - value byte needs bit 7 clear
// RQ25 - address held until new address byte
// RQ26 - parity latched at command strobe trailing edge
// RQ27 - bus drivers enabled only during status
// RQ28 - formatter lines active low except presence
`timescale 1ns/100ps
module tfma_adapter
  import tfma_pkg::*;
#(
  parameter int TC_W = 16,
  parameter logic [7:0] SER_A = SERIAL_A, // arbitrary value
  parameter logic [7:0] SER_B = SERIAL_B // arbitrary value
)(
  input wire logic clk_sys,
  input wire logic srst,
  // formatter side
  input wire logic [7:0] shared_bus_lines_in_n,
  output logic [7:0] shared_bus_lines_out_n,
  output logic shared_bus_lines_oe_n,
  input wire logic shared_bus_parity_in_n,
  output logic shared_bus_parity_out_n,
  input wire logic cmd_addr_strobe_n,
  input wire logic status_read_strobe_n,
  input wire logic wr_byte_strobe_n,
  output logic cmd_parity_fault_n,
  output logic unit_present,
  output logic [8:0] read_channels_n,
  output logic [8:0] amplitude_fault_lines_n,
  output logic capstan_pulse_n,
  // transport side
  input wire logic [8:0] tape_read_channels,
  input wire logic [8:0] tape_amp_fault,
  input wire logic capstan_pulse,
  input wire logic late_gain_ctl,
  input wire logic low_level_active,
  input wire logic [3:0] unit_select_inputs,
  input wire logic [7:0] tape_status,
  input wire logic [2:0] tape_mode_status,
  input wire logic manual_test,
  input wire logic test_data_strobe_n,
  output logic [8:0] tape_write_channels,
  output logic tape_write_strobe,
  output logic [7:0] tape_motion_ctl,
  output logic tape_high_density,
  output logic std_read_level,
  output logic low_read_level_n
);
  tfma_link_if link ();
  tfma_stat_t st;
  tfma_stat_t next_st;
  logic [4:0] sel_addr;
  logic [7:0] cmd_a;
  logic [7:0] cmd_b;
  logic [8:0] amp_loop;
  logic [7:0] thr;
  logic fault;
  logic [TC_W-1:0] tach_cnt;
  logic tach_prev;
  logic [4:0] next_sel_addr;
  logic [7:0] next_cmd_a;
  logic [7:0] next_cmd_b;
  logic [8:0] next_amp_loop;
  logic [7:0] next_thr;
  logic next_fault;
  logic [TC_W-1:0] next_tach_cnt;
  logic [7:0] next_bus_out;
  logic next_par_out;
  logic [8:0] next_wr_ch;
  logic next_wr_stb;
  logic [8:0] next_rd_n;
  logic [8:0] next_amp_n;
  logic loop_rd;
  logic loop_amp;
  logic read_en;

  // ******************************
  // byte decode helpers
  // ******************************
  // address byte: bit 7 set, bits 6 and 5 clear
  function automatic logic is_addr(input logic [7:0] b);
    is_addr = b[BIT_TYPE] && !b[BIT_T6] && !b[BIT_T5]; // RQ23
  endfunction : is_addr

  // status register selected by address
  function automatic logic [7:0] stat_sel(input logic [4:0] a);
    case (a)
      ADR_CMD_A: stat_sel = tape_status; // RQ11
      ADR_CMD_B: stat_sel = {tape_mode_status, late_gain_ctl, // RQ22
        low_level_active, capstan_pulse, unit_select_inputs[3], fault};
      ADR_AMP: stat_sel = SER_A;
      ADR_THR: stat_sel = SER_B;
      ADR_DIAG: stat_sel = {4'h0, unit_select_inputs}; // RQ14
      ADR_TC_HI: stat_sel = tach_cnt[TC_W-1 -: 8]; // RQ18
      ADR_TC_LO: stat_sel = tach_cnt[7:0]; // RQ18
      default: stat_sel = 8'h00;
    endcase
  endfunction : stat_sel

  // ******************************
  // strobe receiver
  // ******************************
  // edge detect and byte capture
  tfma_strobe_rx u_rx (
    .clk_sys(clk_sys),
    .srst(srst),
    .bus_in_n(shared_bus_lines_in_n),
    .par_in_n(shared_bus_parity_in_n),
    .cmd_addr_strobe_n(cmd_addr_strobe_n),
    .wr_byte_strobe_n(wr_byte_strobe_n),
    .status_read_strobe_n(status_read_strobe_n),
    .link(link.rx)
  );

  // loop and enable bits from mode command
  assign loop_rd = cmd_b[CB_LOOP_RD];
  assign loop_amp = cmd_b[CB_LOOP_AMP];
  assign read_en = cmd_b[CB_READ_EN];

  // ******************************
  // command and address registers
  // ******************************
  // decode bytes into address and registers
  // a parity fault is judged anew on every command strobe byte, not on write bytes
  always_comb begin
    next_sel_addr = sel_addr; // RQ25
    next_cmd_a = cmd_a;
    next_cmd_b = cmd_b;
    next_amp_loop = amp_loop;
    next_thr = thr;
    next_fault = fault;
    if (link.cmd_done) begin
      next_fault = link.rx_par_err; // RQ26 RQ5
      if (is_addr(link.rx_byte)) begin
        next_sel_addr = link.rx_byte[ADR_MSB:0]; // RQ23
      end else if (!link.rx_byte[BIT_TYPE]) begin
        // RQ24
        case (sel_addr)
          ADR_CMD_A: next_cmd_a = link.rx_byte;
          ADR_CMD_B: begin
            next_cmd_b = link.rx_byte;
            if (link.rx_byte[CB_LOOP_RD]) begin
              next_cmd_b[CB_READ_EN] = 1'b0; // RQ8
            end
          end
          ADR_AMP: next_amp_loop = {link.rx_par, link.rx_byte}; // RQ10
          ADR_THR: next_thr = link.rx_byte;
          default: next_cmd_a = cmd_a;
        endcase
      end
    end
  end

  // register command state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_addr <= ADR_CMD_A;
      cmd_a <= RST_BYTE;
      cmd_b <= RST_BYTE;
      amp_loop <= 9'h000;
      thr <= RST_THR;
      fault <= 1'b0;
    end else begin
      sel_addr <= next_sel_addr;
      cmd_a <= next_cmd_a;
      cmd_b <= next_cmd_b;
      amp_loop <= next_amp_loop;
      thr <= next_thr;
      fault <= next_fault;
    end
  end

  // ******************************
  // status transfer onto shared bus
  // ******************************
  // status handshake and byte select
  always_comb begin
    next_st = st;
    case (st)
      TFMA_IDLE: if (link.stat_req) next_st = TFMA_DRIVE; // RQ1
      TFMA_DRIVE: if (!link.stat_req) next_st = TFMA_IDLE; // RQ27
      default: next_st = TFMA_IDLE;
    endcase
    next_bus_out = stat_sel(sel_addr); // RQ1
    // odd parity over the byte and its parity bit
    next_par_out = (^next_bus_out) ^ PAR_ODD;
  end

  // register bus drive
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= TFMA_IDLE;
      shared_bus_lines_oe_n <= 1'b1;
      shared_bus_lines_out_n <= 8'hff;
      shared_bus_parity_out_n <= 1'b1;
    end else begin
      st <= next_st;
      shared_bus_lines_oe_n <= (next_st != TFMA_DRIVE); // RQ27 RQ21
      shared_bus_lines_out_n <= ~next_bus_out; // RQ28
      shared_bus_parity_out_n <= ~next_par_out;
    end
  end

  // ******************************
  // write path and tach counter
  // ******************************
  // write data, test path and tach edge
  always_comb begin
    next_wr_ch = tape_write_channels;
    next_wr_stb = 1'b0;
    next_tach_cnt = tach_cnt;
    if (capstan_pulse && !tach_prev) begin
      next_tach_cnt = tach_cnt + 1'b1; // RQ18
    end
    if (manual_test) begin
      next_wr_ch = {9{~test_data_strobe_n}}; // RQ19
      next_wr_stb = ~test_data_strobe_n; // RQ19
    end else if (link.wr_done) begin
      next_wr_ch = {link.rx_par, link.rx_byte}; // RQ12 RQ20 RQ4
      next_wr_stb = 1'b1; // RQ17
    end
  end

  // register write path
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tape_write_channels <= 9'h000;
      tape_write_strobe <= 1'b0;
      tach_cnt <= '0;
      tach_prev <= 1'b0;
    end else begin
      tape_write_channels <= next_wr_ch;
      // strobe rises with the data, one cycle wide outside manual test
      tape_write_strobe <= next_wr_stb; // RQ17
      tach_cnt <= next_tach_cnt;
      tach_prev <= capstan_pulse;
    end
  end

  // ******************************
  // dedicated formatter lines
  // ******************************
  // read and amplitude line sources
  always_comb begin
    next_rd_n = ~(read_en ? tape_read_channels : 9'h000); // RQ7
    if (loop_rd) begin
      next_rd_n = {shared_bus_parity_in_n, shared_bus_lines_in_n}; // RQ8
    end
    next_amp_n = ~tape_amp_fault; // RQ9 RQ16
    if (loop_amp) begin
      next_amp_n = ~amp_loop; // RQ10
    end
  end

  // register formatter and transport lines
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      read_channels_n <= 9'h1ff;
      amplitude_fault_lines_n <= 9'h1ff;
      cmd_parity_fault_n <= 1'b1;
      capstan_pulse_n <= 1'b1;
      unit_present <= 1'b1;
      tape_motion_ctl <= RST_BYTE;
      tape_high_density <= 1'b0;
      std_read_level <= 1'b1;
      low_read_level_n <= 1'b1;
    end else begin
      read_channels_n <= next_rd_n;
      amplitude_fault_lines_n <= next_amp_n;
      cmd_parity_fault_n <= ~next_fault; // RQ5
      capstan_pulse_n <= ~capstan_pulse; // RQ18
      unit_present <= 1'b1; // RQ2
      // motion and density held off on parity fault
      tape_motion_ctl <= next_fault ? RST_BYTE : next_cmd_a; // RQ6
      tape_high_density <= !next_fault && next_cmd_b[CB_HI_DENS]; // RQ6
      std_read_level <= next_thr[TH_STD]; // RQ15
      low_read_level_n <= ~next_thr[TH_LOW]; // RQ15
    end
  end
endmodule : tfma_adapter

// >>> src/tfma_pkg.sv
package tfma_pkg;
  // ******************************
  // register addresses
  // ******************************
  localparam logic [4:0] ADR_CMD_A = 5'h00; // motion command / status a
  localparam logic [4:0] ADR_CMD_B = 5'h01; // mode command / status b
  localparam logic [4:0] ADR_AMP = 5'h02; // amplitude loop / serial a
  localparam logic [4:0] ADR_THR = 5'h03; // threshold / serial b
  localparam logic [4:0] ADR_DIAG = 5'h04; // unit diagnostic status
  localparam logic [4:0] ADR_TC_HI = 5'h07; // tach count high byte
  localparam logic [4:0] ADR_TC_LO = 5'h08; // tach count low byte
  // ******************************
  // byte field layout
  // ******************************
  localparam int BIT_TYPE = 7; // set, with bits 6 and 5 clear, marks an address byte
  localparam int BIT_T6 = 6;
  localparam int BIT_T5 = 5;
  localparam int ADR_MSB = 4;
  localparam logic PAR_ODD = 1'b1; // odd parity over byte plus parity
  // command b bits
  localparam int CB_LOOP_RD = 0;
  localparam int CB_LOOP_AMP = 1;
  localparam int CB_READ_EN = 2;
  localparam int CB_HI_DENS = 3;
  // threshold bits
  localparam int TH_STD = 0;
  localparam int TH_LOW = 1;
  // ******************************
  // reset values
  // ******************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_THR = 8'h01; // standard threshold
  localparam logic [7:0] SERIAL_A = 8'h5a; // arbitrary value
  localparam logic [7:0] SERIAL_B = 8'ha5; // arbitrary value
  typedef enum logic {TFMA_IDLE, TFMA_DRIVE} tfma_stat_t;
endpackage : tfma_pkg

// >>> src/tfma_link_if.sv
`timescale 1ns/100ps
interface tfma_link_if;
  logic cmd_done; // trailing edge of command strobe
  logic wr_done; // trailing edge of write strobe
  logic stat_req; // status strobe held low
  logic [7:0] rx_byte; // received byte, true high
  logic rx_par; // received parity bit, true high
  logic rx_par_err; // parity check of rx byte failed
  modport rx (output cmd_done, wr_done, stat_req, rx_byte, rx_par,
    rx_par_err);
  modport core (input cmd_done, wr_done, stat_req, rx_byte, rx_par,
    rx_par_err);
endinterface : tfma_link_if

// >>> src/tfma_strobe_rx.sv
`timescale 1ns/100ps
module tfma_strobe_rx
  import tfma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] bus_in_n,
  input wire logic par_in_n,
  input wire logic cmd_addr_strobe_n,
  input wire logic wr_byte_strobe_n,
  input wire logic status_read_strobe_n,
  tfma_link_if.rx link
);
  logic cmd_prev;
  logic wr_prev;
  logic [7:0] byte_q;
  logic par_q;
  logic next_cmd_prev;
  logic next_wr_prev;
  logic [7:0] next_byte_q;
  logic next_par_q;

  // ******************************
  // strobe edges and byte capture
  // ******************************
  // byte follows the lines while either inbound strobe is low
  always_comb begin
    next_cmd_prev = cmd_addr_strobe_n;
    next_wr_prev = wr_byte_strobe_n;
    next_byte_q = byte_q;
    next_par_q = par_q;
    if (!cmd_addr_strobe_n || !wr_byte_strobe_n) begin
      next_byte_q = ~bus_in_n; // RQ28
      next_par_q = ~par_in_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_prev <= 1'b1;
      wr_prev <= 1'b1;
      byte_q <= RST_BYTE;
      par_q <= 1'b0;
    end else begin
      cmd_prev <= next_cmd_prev;
      wr_prev <= next_wr_prev;
      byte_q <= next_byte_q;
      par_q <= next_par_q;
    end
  end

  // trailing edges end a transfer
  assign link.cmd_done = !cmd_prev && cmd_addr_strobe_n; // RQ3
  assign link.wr_done = !wr_prev && wr_byte_strobe_n; // RQ4
  assign link.stat_req = !status_read_strobe_n; // RQ1
  assign link.rx_byte = byte_q;
  assign link.rx_par = par_q;
  assign link.rx_par_err = ((^{byte_q, par_q}) != PAR_ODD);
endmodule : tfma_strobe_rx

// >>> verification/tfma_adapter_chk.sv
`timescale 1ns/100ps
// ****
// port checker
// ****
module tfma_adapter_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] shared_bus_lines_out_n,
  input wire logic shared_bus_lines_oe_n,
  input wire logic shared_bus_parity_out_n,
  input wire logic cmd_addr_strobe_n,
  input wire logic status_read_strobe_n,
  input wire logic wr_byte_strobe_n,
  input wire logic cmd_parity_fault_n,
  input wire logic unit_present,
  input wire logic capstan_pulse,
  input wire logic capstan_pulse_n,
  input wire logic manual_test,
  input wire logic tape_write_strobe,
  input wire logic [7:0] tape_motion_ctl,
  input wire logic tape_high_density
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // end of a write byte and a normal-mode pulse
  sequence s_wr_end;
    $rose(wr_byte_strobe_n) && !manual_test;
  endsequence
  sequence s_wr_pulse;
    !manual_test ##1 tape_write_strobe && !manual_test;
  endsequence
  a_present_high: assert property (unit_present)
    else $error("presence line low");
  a_stat_drive: assert property (
    !status_read_strobe_n |=> !shared_bus_lines_oe_n)
    else $error("status not driven");
  a_bus_release: assert property (
    status_read_strobe_n |=> shared_bus_lines_oe_n)
    else $error("bus driven outside status");
  a_stat_parity: assert property (
    !shared_bus_lines_oe_n |->
    (^{shared_bus_lines_out_n, shared_bus_parity_out_n}) == 1'b0)
    else $error("status parity wrong");
  a_fault_gate: assert property (
    !cmd_parity_fault_n |-> tape_motion_ctl == 8'h00 && !tape_high_density)
    else $error("motion released during fault");
  a_fault_cause: assert property (
    $fell(cmd_parity_fault_n) |-> $past(cmd_addr_strobe_n))
    else $error("fault before strobe end");
  a_wr_follow: assert property (s_wr_end |-> ##[1:3] tape_write_strobe)
    else $error("no write strobe");
  a_wr_single: assert property (s_wr_pulse |=> !tape_write_strobe)
    else $error("write strobe too long");
  a_tach_copy: assert property (
    1'b1 |=> capstan_pulse_n != $past(capstan_pulse))
    else $error("tach copy wrong");
endmodule : tfma_adapter_chk

bind tfma_adapter tfma_adapter_chk i_chk (.clk_sys, .srst,
  .shared_bus_lines_out_n, .shared_bus_lines_oe_n, .shared_bus_parity_out_n,
  .cmd_addr_strobe_n, .status_read_strobe_n, .wr_byte_strobe_n,
  .cmd_parity_fault_n, .unit_present, .capstan_pulse, .capstan_pulse_n,
  .manual_test, .tape_write_strobe, .tape_motion_ctl, .tape_high_density);

// >>> verification/tfma_fmt_model.sv
`timescale 1ns/100ps
// ****
// formatter model
// ****
module tfma_fmt_model (
  input wire logic clk_sys,
  input wire logic [7:0] shared_bus_lines_out_n,
  input wire logic shared_bus_lines_oe_n,
  input wire logic shared_bus_parity_out_n,
  output logic [7:0] shared_bus_lines_in_n,
  output logic shared_bus_parity_in_n,
  output logic cmd_addr_strobe_n,
  output logic status_read_strobe_n,
  output logic wr_byte_strobe_n
);
  logic [7:0] drv_n = 8'hff;
  logic drv_par_n = 1'b1;
  logic drv_en = 1'b0;
  initial begin
    cmd_addr_strobe_n = 1'b1;
    status_read_strobe_n = 1'b1;
    wr_byte_strobe_n = 1'b1;
  end
  // wire level: adapter, formatter, else terminator pull-up
  assign shared_bus_lines_in_n = !shared_bus_lines_oe_n ?
    shared_bus_lines_out_n : drv_en ? drv_n : 8'hff;
  assign shared_bus_parity_in_n = !shared_bus_lines_oe_n ?
    shared_bus_parity_out_n : drv_en ? drv_par_n : 1'b1;
  // one byte transfer, kind 0 command, 1 write data
  task put(input int k, input logic [7:0] b, input logic bad);
    @(negedge clk_sys);
    drv_n = ~b;
    drv_par_n = (^b) ^ bad; // odd parity, bad flips it
    drv_en = 1'b1;
    if (k == 0) cmd_addr_strobe_n = 1'b0;
    else wr_byte_strobe_n = 1'b0;
    @(negedge clk_sys);
    cmd_addr_strobe_n = 1'b1;
    wr_byte_strobe_n = 1'b1;
    @(negedge clk_sys);
    drv_en = 1'b0; // nothing else shares the bus meanwhile
    repeat (3) @(negedge clk_sys);
  endtask : put
  // status byte read from the selected address
  task get(output logic [7:0] b);
    @(negedge clk_sys);
    status_read_strobe_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    b = ~shared_bus_lines_in_n;
    status_read_strobe_n = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask : get
endmodule : tfma_fmt_model

// >>> verification/tfma_adapter_tb.sv
`timescale 1ns/100ps
// ****
// adapter testbench
// ****
module tfma_adapter_tb;
  logic clk_sys = 1'b0, srst = 1'b1, capstan_pulse = 1'b0;
  logic late_gain_ctl = 1'b0, low_level_active = 1'b0;
  logic manual_test = 1'b0, test_data_strobe_n = 1'b1;
  logic [8:0] tape_read_channels = 9'h1a5, tape_amp_fault = 9'h100;
  logic [3:0] unit_select_inputs = 4'hd;
  logic [7:0] tape_status = 8'h3c;
  logic [2:0] tape_mode_status = 3'h5;
  logic [7:0] shared_bus_lines_in_n, shared_bus_lines_out_n, b;
  logic shared_bus_lines_oe_n, shared_bus_parity_in_n;
  logic shared_bus_parity_out_n, cmd_addr_strobe_n, status_read_strobe_n;
  logic wr_byte_strobe_n, cmd_parity_fault_n, unit_present;
  logic capstan_pulse_n, tape_write_strobe, tape_high_density;
  logic std_read_level, low_read_level_n;
  logic [8:0] read_channels_n, amplitude_fault_lines_n, tape_write_channels;
  logic [7:0] tape_motion_ctl;
  int n_errors = 0, n_tests = 0;
  tfma_adapter i_dut (.*);
  tfma_fmt_model i_fmt (.*);
  always #20 clk_sys = ~clk_sys;
  // compare and count
  task chk(input string nm, input logic [8:0] e, input logic [8:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // watchdog
  initial begin
    #100000;
    n_errors++;
    summarize;
  end
  // main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    chk("present", 9'h001, unit_present);
    chk("oe", 9'h001, shared_bus_lines_oe_n);
    chk("std", 9'h001, std_read_level);
    i_fmt.put(0, 8'h80, 1'b0);
    i_fmt.put(0, 8'h15, 1'b0);
    chk("motion", 9'h015, tape_motion_ctl);
    i_fmt.put(0, 8'hc2, 1'b0);
    chk("ignored", 9'h015, tape_motion_ctl);
    for (int i = 0; i < 2; i++) begin
      tape_status = 8'h3c ^ {8{i[0]}};
      i_fmt.get(b);
      chk("stat a", tape_status, b);
    end
    i_fmt.put(0, 8'h17, 1'b1);
    chk("fault", 9'h000, cmd_parity_fault_n);
    chk("held", 9'h000, tape_motion_ctl);
    i_fmt.put(0, 8'h15, 1'b0);
    chk("clear", 9'h001, cmd_parity_fault_n);
    i_fmt.put(0, 8'h82, 1'b0);
    i_fmt.put(0, 8'h55, 1'b0);
    late_gain_ctl = 1'b1;
    i_fmt.put(0, 8'h81, 1'b0);
    i_fmt.get(b);
    chk("stat b", 9'h0b2, b);
    i_fmt.put(0, 8'h0b, 1'b0);
    chk("density", 9'h001, tape_high_density);
    chk("amp loop", 9'h0aa, amplitude_fault_lines_n);
    i_fmt.drv_n = 8'hc3;
    i_fmt.drv_en = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("loop", 9'h0c3, read_channels_n[7:0]);
    i_fmt.drv_en = 1'b0;
    i_fmt.put(0, 8'h04, 1'b0);
    chk("read", ~tape_read_channels, read_channels_n);
    chk("amp", ~tape_amp_fault, amplitude_fault_lines_n);
    i_fmt.put(0, 8'h83, 1'b0);
    i_fmt.put(0, 8'h02, 1'b0);
    chk("std", 9'h000, std_read_level);
    chk("low", 9'h000, low_read_level_n);
    i_fmt.put(0, 8'h84, 1'b0);
    i_fmt.get(b);
    chk("diag", 9'h00d, b);
    fork
      i_fmt.put(1, 8'ha7, 1'b0);
      for (int k = 0; k < 10; k++) begin
        @(negedge clk_sys);
        if (tape_write_strobe === 1'b1) break;
      end
    join_any
    chk("wstrobe", 9'h001, tape_write_strobe);
    chk("wdata", 9'h0a7, tape_write_channels);
    wait fork;
    manual_test = 1'b1;
    test_data_strobe_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("test", 9'h1ff, tape_write_channels);
    chk("tstrobe", 9'h001, tape_write_strobe);
    manual_test = 1'b0;
    test_data_strobe_n = 1'b1;
    capstan_pulse = 1'b1;
    @(negedge clk_sys);
    chk("tach", 9'h000, capstan_pulse_n);
    capstan_pulse = 1'b0;
    i_fmt.put(0, 8'h88, 1'b0);
    i_fmt.get(b);
    chk("tach lo", 9'h001, b);
    summarize;
  end
endmodule : tfma_adapter_tb
